// file: common/cam_ctrl_defs.svh
// Register offsets, field positions, reset values and timing counts of the camera control block.
// Assumes a 40 MHz APB clock and byte addresses on an 8-bit paddr.
`ifndef CAM_CTRL_DEFS_SVH
`define CAM_CTRL_DEFS_SVH

`define OFF_CTRL 8'h00
`define OFF_GAIN 8'h04
`define OFF_SHUTTER 8'h08
`define OFF_IRIS 8'h0c
`define OFF_BRIGHT 8'h10
`define OFF_AE 8'h14
`define OFF_HUE 8'h18
`define OFF_SAT 8'h1c
`define OFF_WB 8'h20
`define OFF_STATUS 8'h24
`define OFF_CMD 8'h28

`define CTRL_ISO 0
`define CTRL_TRIG 1
`define CTRL_AGAIN 2
`define CTRL_ASHUT 3
`define CTRL_AIRIS 4
`define CTRL_GAMMA 6:5
`define CTRL_WB 8:7
`define CTRL_CTEMP 10:9
`define CMD_SHOT 0
`define CMD_PUSH 1

`define GAIN_MAX 5'h12
`define CODE_MID 8'h80
`define IRIS_CLOSED 8'hff
`define WB_3200_R 8'h60
`define WB_3200_B 8'ha8
`define WB_5600_R 8'h80
`define WB_5600_B 8'h80
`define AE_WINDOW 9'h08
`define HUE_DEG 15

`define CLK_NS 25
`define TICK_NS 10000
`define TICK_CYC (`TICK_NS / `CLK_NS)
`define EXPO_LONG_US 5000000
`define EXPO_SHORT_US 10
`define EIRIS_LONG_US 33333
`define EIRIS_SHORT_US 500
`define US_TO_TICK(t) ((t) / (`TICK_NS / 1000))
`define TRIG_MIN_US 1000
`define SHOT_MAX_MS 70
`define BLINK_MS 500
`define MS_TO_CYC(t) ((t) * 1000000 / `CLK_NS)
`define US_TO_CYC(t) ((t) * 1000 / `CLK_NS)

`endif

// file: common/cam_ctrl_pkg.sv
// Types shared by the camera control block and its bench.
// Assumes nothing beyond the defs header for numbers.
package cam_ctrl_pkg;
	typedef enum logic [1:0] {GAMMA_MONITOR, GAMMA_LINEAR, GAMMA_WIDE} gamma_e;
	typedef enum logic [1:0] {WB_MANUAL, WB_ONE_PUSH, WB_TRACK} wb_mode_e;
	typedef enum logic [2:0] {SH_IDLE, SH_ARM, SH_EXPOSE, SH_ALIGN, SH_SEND} shot_state_e;
	typedef struct packed {
		logic [4:0] gain_db;
		logic [19:0] expo_tick;
		logic [7:0] iris;
		logic [5:0] black;
		gamma_e gamma;
		logic [7:0] red_gain;
		logic [7:0] blue_gain;
		logic signed [11:0] hue_rot;
		logic [7:0] sat_scale;
	} image_cfg_s;
	typedef struct packed {
		logic [7:0] luma;
		logic signed [7:0] red_err;
		logic signed [7:0] blue_err;
	} meas_s;
	typedef struct packed {
		logic green;
		logic orange;
	} lamp_s;
endpackage

// file: hw/cam_ctrl.sv
// Camera capture control: APB registers, exposure loops, colour settings, frame sequencing, lamp.
// Assumes synchronous inputs on pclk, a measurement pulse per frame and a frame_done pulse from the video path.
// Behaviour
// - Green lamp blinks while streaming is off and no frame is being sent.
// - No image output after reset until host enables it.
// - Manual gain 0 to 18 dB in 1 dB steps.
// - Automatic gain adjusts toward proper exposure within 0 to 18 dB.
// - Exposure time from 10 us up to 5 s.
// - Electronic iris picks exposure between 1/30 and 1/2000 s.
// - Automatic lens iris drives aperture over full range.
// - Exposure compensation only acts while some loop is automatic.
// - Brightness code sets black level: 0, 1, 50 luma.
// - Three gamma settings: monitor, linear, wide linear.
// - White balance manual, single-push or continuous tracking.
// - Colour temperature presets load 3200 K or 5600 K gains.
// - Hue code rotates hue, 80h neutral, extremes about 15 degrees.
// - Saturation code scales 0, unity at 80h, about double.
// - Lamp orange while isochronous output is on.
// - Single-frame command sends exactly one frame, only with streaming off.
// - Single-frame exposure starts within 70 ms of the command.
// - Lamp orange while a single frame is sent.
// - Trigger mode stops streaming at once and holds it off.
// - Each trigger exposes one frame for shutter time, then sends it.
// - Trigger-to-output delay follows exposure time and reference pulse phase.
//
// The placing of the registers and register access over APB were left to the implementer.
`include "cam_ctrl_defs.svh"

module cam_ctrl
	import cam_ctrl_pkg::*;
#(
	parameter int TRIG_MIN_CYC = `US_TO_CYC(`TRIG_MIN_US),
	parameter int SHOT_MAX_CYC = `MS_TO_CYC(`SHOT_MAX_MS),
	parameter int BLINK_CYC = `MS_TO_CYC(`BLINK_MS)
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic external_trigger_input_n,
	input wire logic vertical_reference_pulse,
	input wire logic meas_valid,
	input wire meas_s meas,
	input wire logic frame_done,
	output image_cfg_s image_cfg,
	output logic stream_on,
	output logic frame_start,
	output logic exposing,
	output lamp_s lamp
);
	localparam logic [19:0] EXPO_LONG = 20'(`US_TO_TICK(`EXPO_LONG_US));
	localparam logic [19:0] EXPO_SHORT = 20'(`US_TO_TICK(`EXPO_SHORT_US));
	localparam logic [19:0] EIRIS_LONG = 20'(`US_TO_TICK(`EIRIS_LONG_US));
	localparam logic [19:0] EIRIS_SHORT = 20'(`US_TO_TICK(`EIRIS_SHORT_US));
	localparam int TW = $clog2(TRIG_MIN_CYC + 1);
	localparam int AW = $clog2(SHOT_MAX_CYC + 1);
	localparam int BW = $clog2(BLINK_CYC + 1);

	logic [10:0] ctrl_q;
	logic [4:0] gain_q;
	logic [19:0] expo_q;
	logic [7:0] iris_q, bright_q, ae_q, hue_q, sat_q, red_q, blue_q;
	logic push_q;
	logic [31:0] prdata_q;
	shot_state_e state_q;
	logic stream_q, frame_start_q;
	lamp_s lamp_q;
	image_cfg_s cfg_q;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// APB decode
	logic setup, wr, addr_ok;
	assign setup = psel & ~penable;
	assign wr = psel & penable & pwrite;
	always_comb
	begin
		unique case (paddr)
			`OFF_CTRL, `OFF_GAIN, `OFF_SHUTTER, `OFF_IRIS, `OFF_BRIGHT, `OFF_AE,
			`OFF_HUE, `OFF_SAT, `OFF_WB, `OFF_STATUS, `OFF_CMD: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;
	assign prdata = prdata_q;

	logic w_ctrl, w_gain, w_shut, w_iris, w_wb, shot_cmd, push_cmd;
	assign w_ctrl = wr & (paddr == `OFF_CTRL);
	assign w_gain = wr & (paddr == `OFF_GAIN);
	assign w_shut = wr & (paddr == `OFF_SHUTTER);
	assign w_iris = wr & (paddr == `OFF_IRIS);
	assign w_wb = wr & (paddr == `OFF_WB);
	assign shot_cmd = wr & (paddr == `OFF_CMD) & pwdata[`CMD_SHOT];
	assign push_cmd = wr & (paddr == `OFF_CMD) & pwdata[`CMD_PUSH];

	// Read data latched in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_q <= 32'h0;
		else if (setup)
		begin
			unique case (paddr)
				`OFF_CTRL: prdata_q <= {21'h0, ctrl_q};
				`OFF_GAIN: prdata_q <= {27'h0, gain_q};
				`OFF_SHUTTER: prdata_q <= {12'h0, expo_q};
				`OFF_IRIS: prdata_q <= {24'h0, iris_q};
				`OFF_BRIGHT: prdata_q <= {24'h0, bright_q};
				`OFF_AE: prdata_q <= {24'h0, ae_q};
				`OFF_HUE: prdata_q <= {24'h0, hue_q};
				`OFF_SAT: prdata_q <= {24'h0, sat_q};
				`OFF_WB: prdata_q <= {16'h0, blue_q, red_q};
				`OFF_STATUS: prdata_q <= {25'h0, push_q, lamp_q, stream_q, 3'(state_q)};
				default: prdata_q <= 32'h0;
			endcase
		end
	end

	// Plain setting registers, streaming off after reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q <= 11'h0;
			bright_q <= `CODE_MID;
			ae_q <= `CODE_MID;
			hue_q <= `CODE_MID;
			sat_q <= `CODE_MID;
		end
		else if (wr)
		begin
			if (paddr == `OFF_CTRL)
				ctrl_q <= pwdata[10:0];
			if (paddr == `OFF_BRIGHT)
				bright_q <= pwdata[7:0];
			if (paddr == `OFF_AE)
				ae_q <= pwdata[7:0];
			if (paddr == `OFF_HUE)
				hue_q <= pwdata[7:0];
			if (paddr == `OFF_SAT)
				sat_q <= pwdata[7:0];
		end
	end

	logic iso_en, trig_mode, a_gain, a_shut, a_iris, any_auto;
	assign iso_en = ctrl_q[`CTRL_ISO];
	assign trig_mode = ctrl_q[`CTRL_TRIG];
	assign a_gain = ctrl_q[`CTRL_AGAIN];
	assign a_shut = ctrl_q[`CTRL_ASHUT];
	assign a_iris = ctrl_q[`CTRL_AIRIS];
	assign any_auto = a_gain | a_shut | a_iris;

	// Exposure target with compensation
	logic [8:0] target, lo_lim, hi_lim;
	logic dark, bright;
	always_comb
	begin
		if (!any_auto)
			target = {1'b0, `CODE_MID};
		else if (ae_q < `CODE_MID)
			target = 9'(8'h40 + {1'b0, ae_q[7:1]});
		else
			target = 9'({1'b0, `CODE_MID} + {2'b0, ae_q[6:0]} / 9'd2);
		lo_lim = (target > `AE_WINDOW) ? target - `AE_WINDOW : 9'h0;
		hi_lim = target + `AE_WINDOW;
	end
	assign dark = meas_valid & ({1'b0, meas.luma} < lo_lim);
	assign bright = meas_valid & ({1'b0, meas.luma} > hi_lim);
	no_comp_a: assert property (!any_auto |-> target == 9'h080) else $error("compensation without auto");

	// Gain, manual or automatic
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			gain_q <= 5'h0;
		else if (w_gain)
			gain_q <= (pwdata > 32'(`GAIN_MAX)) ? `GAIN_MAX : pwdata[4:0];
		else if (a_gain & dark & (gain_q < `GAIN_MAX))
			gain_q <= gain_q + 5'h1;
		else if (a_gain & bright & (gain_q != 5'h0))
			gain_q <= gain_q - 5'h1;
	end
	gain_range_a: assert property (gain_q <= `GAIN_MAX) else $error("gain above 18 dB");

	// Exposure time, manual or electronic iris
	logic [19:0] e_cl, e_up, e_dn;
	always_comb
	begin
		e_cl = (expo_q > EIRIS_LONG) ? EIRIS_LONG : (expo_q < EIRIS_SHORT) ? EIRIS_SHORT : expo_q;
		e_up = e_cl + (e_cl >> 3) + 20'h1;
		e_dn = e_cl - (e_cl >> 3) - 20'h1;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			expo_q <= EIRIS_LONG;
		else if (w_shut)
			expo_q <= (pwdata[31:0] > 32'(EXPO_LONG)) ? EXPO_LONG :
				(pwdata[19:0] < EXPO_SHORT) ? EXPO_SHORT : pwdata[19:0];
		else if (a_shut & dark)
			expo_q <= (e_up > EIRIS_LONG) ? EIRIS_LONG : e_up;
		else if (a_shut & bright)
			expo_q <= (e_dn < EIRIS_SHORT) ? EIRIS_SHORT : e_dn;
		else if (a_shut & meas_valid)
			expo_q <= e_cl;
	end
	eiris_range_a: assert property (a_shut && !w_shut && meas_valid && (dark || bright)
		|=> expo_q >= EIRIS_SHORT && expo_q <= EIRIS_LONG) else $error("iris exposure out of range");

	// Lens aperture, 0 fully open
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			iris_q <= 8'h0;
		else if (w_iris)
			iris_q <= pwdata[7:0];
		else if (a_iris & dark & (iris_q != 8'h0))
			iris_q <= iris_q - 8'h1;
		else if (a_iris & bright & (iris_q != `IRIS_CLOSED))
			iris_q <= iris_q + 8'h1;
	end

	// White balance gains
	wb_mode_e wb_mode;
	logic wb_step;
	assign wb_mode = wb_mode_e'(ctrl_q[`CTRL_WB]);
	assign wb_step = meas_valid & ((wb_mode == WB_TRACK) | ((wb_mode == WB_ONE_PUSH) & push_q));
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			push_q <= 1'b0;
		else
			push_q <= push_cmd | (push_q & ~meas_valid);
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			red_q <= `WB_5600_R;
			blue_q <= `WB_5600_B;
		end
		else if (w_wb)
		begin
			red_q <= pwdata[7:0];
			blue_q <= pwdata[15:8];
		end
		else if (w_ctrl & (pwdata[`CTRL_CTEMP] == 2'h1))
		begin
			red_q <= `WB_3200_R;
			blue_q <= `WB_3200_B;
		end
		else if (w_ctrl & (pwdata[`CTRL_CTEMP] == 2'h2))
		begin
			red_q <= `WB_5600_R;
			blue_q <= `WB_5600_B;
		end
		else if (wb_step)
		begin
			if (meas.red_err > 0 && red_q != 8'h0)
				red_q <= red_q - 8'h1;
			else if (meas.red_err < 0 && red_q != 8'hff)
				red_q <= red_q + 8'h1;
			if (meas.blue_err > 0 && blue_q != 8'h0)
				blue_q <= blue_q - 8'h1;
			else if (meas.blue_err < 0 && blue_q != 8'hff)
				blue_q <= blue_q + 8'h1;
		end
	end

	// Trigger synchroniser and width filter
	logic trig_s1, trig_s2, trig_fire;
	logic [TW-1:0] low_cnt;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			trig_s1 <= 1'b1;
			trig_s2 <= 1'b1;
		end
		else
		begin
			trig_s1 <= external_trigger_input_n;
			trig_s2 <= trig_s1;
		end
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			low_cnt <= '0;
		else if (trig_s2)
			low_cnt <= '0;
		else if (low_cnt != TW'(TRIG_MIN_CYC))
			low_cnt <= low_cnt + TW'(1);
	end
	assign trig_fire = ~trig_s2 & (low_cnt == TW'(TRIG_MIN_CYC - 1));
	trig_width_a: assert property (trig_fire |-> !trig_s2 && $past(!trig_s2)) else $error("short trigger taken");

	// Frame sequencer
	logic [AW-1:0] arm_cnt;
	logic [8:0] cyc_cnt;
	logic [19:0] tick_cnt, expo_lat;
	logic tick, shot_ok;
	assign tick = (cyc_cnt == 9'(`TICK_CYC - 1));
	assign shot_ok = shot_cmd & ~iso_en & ~trig_mode & (state_q == SH_IDLE);
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_q <= SH_IDLE;
		else
		begin
			unique case (state_q)
				SH_IDLE:
					if (trig_mode & trig_fire)
						state_q <= SH_EXPOSE;
					else if (shot_ok)
						state_q <= SH_ARM;
				SH_ARM:
					if (vertical_reference_pulse | (arm_cnt == AW'(SHOT_MAX_CYC - 1)))
						state_q <= SH_EXPOSE;
				SH_EXPOSE:
					if (tick & (tick_cnt == expo_lat - 20'h1))
						state_q <= SH_ALIGN;
				SH_ALIGN:
					if (vertical_reference_pulse)
						state_q <= SH_SEND;
				SH_SEND:
					if (frame_done)
						state_q <= SH_IDLE;
			endcase
		end
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			arm_cnt <= '0;
		else if (state_q == SH_ARM)
			arm_cnt <= arm_cnt + AW'(1);
		else
			arm_cnt <= '0;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cyc_cnt <= 9'h0;
			tick_cnt <= 20'h0;
			expo_lat <= EXPO_SHORT;
		end
		else if (state_q != SH_EXPOSE)
		begin
			cyc_cnt <= 9'h0;
			tick_cnt <= 20'h0;
			expo_lat <= expo_q;
		end
		else
		begin
			cyc_cnt <= tick ? 9'h0 : cyc_cnt + 9'h1;
			if (tick)
				tick_cnt <= tick_cnt + 20'h1;
		end
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			frame_start_q <= 1'b0;
		else
			frame_start_q <= (state_q == SH_ALIGN) & vertical_reference_pulse;
	end
	assign exposing = (state_q == SH_EXPOSE);
	assign frame_start = frame_start_q;

	sequence trig_taken_s;
		(state_q == SH_IDLE) && trig_mode && trig_fire;
	endsequence
	sequence expose_s;
		state_q == SH_EXPOSE;
	endsequence
	trig_expose_a: assert property (trig_taken_s |=> expose_s) else $error("trigger did not start exposure");
	shot_busy_a: assert property (shot_cmd && (state_q != SH_IDLE || iso_en) && !(trig_mode && trig_fire)
		|=> $stable(state_q) || state_q != SH_ARM) else $error("single frame taken while busy");
	shot_bound_a: assert property (state_q == SH_ARM |-> arm_cnt < AW'(SHOT_MAX_CYC)) else $error("arm too long");

	// Streaming enable and lamp
	logic [BW-1:0] blink_cnt;
	logic blink_q;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			stream_q <= 1'b0;
		else
			stream_q <= iso_en & ~trig_mode;
	end
	assign stream_on = stream_q;
	trig_stop_a: assert property (trig_mode |=> !stream_on) else $error("stream during trigger mode");

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			blink_cnt <= '0;
			blink_q <= 1'b1;
		end
		else if (blink_cnt == BW'(BLINK_CYC - 1))
		begin
			blink_cnt <= '0;
			blink_q <= ~blink_q;
		end
		else
			blink_cnt <= blink_cnt + BW'(1);
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			lamp_q <= '0;
		else
		begin
			lamp_q.orange <= stream_q | (state_q == SH_SEND);
			lamp_q.green <= ~stream_q & (state_q != SH_SEND) & blink_q;
		end
	end
	assign lamp = lamp_q;
	lamp_orange_a: assert property (stream_on || state_q == SH_SEND |=> lamp.orange && !lamp.green)
		else $error("lamp not orange");

	// Image settings
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cfg_q <= '0;
		else
		begin
			cfg_q.gain_db <= gain_q;
			cfg_q.expo_tick <= expo_q;
			cfg_q.iris <= iris_q;
			cfg_q.black <= bright_q[7] ? 6'(7'h01 + 7'((14'(bright_q[6:0]) * 14'd25) >> 6)) : 6'h0;
			cfg_q.gamma <= (ctrl_q[`CTRL_GAMMA] == 2'h3) ? GAMMA_MONITOR : gamma_e'(ctrl_q[`CTRL_GAMMA]);
			cfg_q.red_gain <= red_q;
			cfg_q.blue_gain <= blue_q;
			cfg_q.hue_rot <= 12'(($signed({1'b0, hue_q}) - 9'sd128) * 12'sd`HUE_DEG);
			cfg_q.sat_scale <= sat_q;
		end
	end
	assign image_cfg = cfg_q;
	black_mid_a: assert property (bright_q == `CODE_MID |=> image_cfg.black == 6'h01) else $error("black level at mid");
endmodule

// file: test/cam_far_end.sv
// Far-side model: reference pulses, exposure measurements, frame completion and the trigger source.
// Assumes the block's pclk and presetn; the bench calls its tasks right after a rising edge.
module cam_far_end
	import cam_ctrl_pkg::*;
#(
	parameter int VD_PERIOD = 100,
	parameter int FRAME_LEN = 30
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic frame_start,
	output logic external_trigger_input_n,
	output logic vertical_reference_pulse,
	output logic meas_valid,
	output meas_s meas,
	output logic frame_done
);
	timeunit 1ns;
	timeprecision 1ps;
	int vd_cnt;
	int send_cnt;
	initial
	begin
		external_trigger_input_n = 1'b1;
		meas_valid = 1'b0;
		meas = '0;
	end
	// Reference pulse once per frame period
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			vd_cnt <= 0;
			vertical_reference_pulse <= 1'b0;
		end
		else
		begin
			vd_cnt <= (vd_cnt == VD_PERIOD - 1) ? 0 : vd_cnt + 1;
			vertical_reference_pulse <= (vd_cnt == VD_PERIOD - 1);
		end
	end
	// Video path finishes a frame some cycles after its start
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			send_cnt <= 0;
			frame_done <= 1'b0;
		end
		else
		begin
			frame_done <= (send_cnt == 1);
			if (frame_start)
				send_cnt <= FRAME_LEN;
			else if (send_cnt != 0)
				send_cnt <= send_cnt - 1;
		end
	end
	// Low pulse; the bench picks short ones only to test rejection
	task automatic pull_trigger(input int cycles);
		external_trigger_input_n <= 1'b0;
		repeat (cycles) @(posedge pclk);
		external_trigger_input_n <= 1'b1;
		@(posedge pclk);
	endtask
	task automatic send_meas(input logic [7:0] luma, input logic [7:0] r, input logic [7:0] b);
		meas_valid <= 1'b1;
		meas <= {luma, r, b};
		@(posedge pclk);
		meas_valid <= 1'b0;
		meas <= ~{luma, r, b};
		repeat (4) @(posedge pclk);
	endtask
endmodule

// file: test/camera_capture_control_tb.sv
// Self-checking bench of the camera control block.
// Assumes the far-side model and short counts for trigger width, arm time and blink.
`include "cam_ctrl_defs.svh"
module camera_capture_control_tb
	import cam_ctrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TRIG_MIN = 20;
	localparam int SHOT_MAX = 50;
	localparam int BLINK = 8;
	localparam int LIMIT = 20000;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, g;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic external_trigger_input_n, vertical_reference_pulse, meas_valid, frame_done;
	logic stream_on, frame_start, exposing, exposing_d, trig_d;
	meas_s meas;
	image_cfg_s image_cfg;
	lamp_s lamp;
	int fails = 0, cmp_count = 0, cycles = 0, fs_count = 0, exp_rises = 0;
	int fs_cyc, rise_cyc, fall_cyc, n, k, v, c;
	int corner [3] = '{32'h0, 32'h80, 32'hff};

	cam_ctrl #(.TRIG_MIN_CYC(TRIG_MIN), .SHOT_MAX_CYC(SHOT_MAX), .BLINK_CYC(BLINK)) u_dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .external_trigger_input_n(external_trigger_input_n),
		.vertical_reference_pulse(vertical_reference_pulse), .meas_valid(meas_valid), .meas(meas),
		.frame_done(frame_done), .image_cfg(image_cfg), .stream_on(stream_on), .frame_start(frame_start),
		.exposing(exposing), .lamp(lamp));
	cam_far_end u_far (.pclk(pclk), .presetn(presetn), .frame_start(frame_start),
		.external_trigger_input_n(external_trigger_input_n), .vertical_reference_pulse(vertical_reference_pulse),
		.meas_valid(meas_valid), .meas(meas), .frame_done(frame_done));

	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	// Event monitor and hang limit
	always @(posedge pclk)
	begin
		cycles <= cycles + 1;
		exposing_d <= exposing;
		trig_d <= external_trigger_input_n;
		if (frame_start === 1'b1)
		begin
			fs_count <= fs_count + 1;
			fs_cyc <= cycles;
		end
		if (exposing === 1'b1 && exposing_d === 1'b0)
		begin
			exp_rises <= exp_rises + 1;
			rise_cyc <= cycles;
		end
		if (external_trigger_input_n === 1'b0 && trig_d === 1'b1)
			fall_cyc <= cycles;
		if (cycles == LIMIT)
		begin
			fails++;
			final_report();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		repeat (2) @(posedge pclk);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(rd, e);
	endtask
	task automatic wait_change(ref int cnt, input int base, input int lim);
		int t;
		t = 0;
		while (cnt == base && t < lim)
		begin
			@(posedge pclk);
			t++;
		end
		check(32'(t < lim), 32'h1);
	endtask
	task automatic gains(input logic [7:0] r, input logic [7:0] b);
		check({image_cfg.blue_gain, image_cfg.red_gain}, {b, r});
	endtask
	function automatic logic [31:0] clamp(input int x, input int lo, input int hi);
		return (x < lo) ? 32'(lo) : (x > hi) ? 32'(hi) : 32'(x);
	endfunction

	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		void'($urandom(58161));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		check(32'(stream_on), 32'h0);
		rdchk(`OFF_CTRL, 32'h0);
		rdchk(`OFF_GAIN, 32'h0);
		rdchk(`OFF_SHUTTER, 32'd3333);
		rdchk(`OFF_BRIGHT, 32'h80);
		rdchk(`OFF_HUE, 32'h80);
		rdchk(`OFF_SAT, 32'h80);
		rdchk(`OFF_WB, 32'h8080);
		apb(1'b0, 8'h3c, 32'h0);
		check({rd[30:0], err}, 32'h1);
		n = 0;
		repeat (4 * BLINK)
		begin
			g = lamp.green;
			@(posedge pclk);
			if (lamp.green !== g)
				n++;
		end
		check(32'(n >= 3 && lamp.orange === 1'b0), 32'h1);
		for (int i = 0; i < 8; i++)
		begin
			v = (i < 3) ? corner[i] % 20 + (i == 2 ? 0 : i) : $urandom % 32;
			wr(`OFF_GAIN, v);
			check(32'(image_cfg.gain_db), clamp(v, 0, 18));
			v = (i < 3) ? 500000 * i + (i == 2 ? 1 : 0) : $urandom % 600000;
			wr(`OFF_SHUTTER, v);
			check(32'(image_cfg.expo_tick), clamp(v, 1, 500000));
		end
		for (int i = 0; i < 5; i++)
		begin
			c = (i < 3) ? corner[i] : $urandom % 256;
			wr(`OFF_BRIGHT, c);
			wr(`OFF_HUE, c);
			wr(`OFF_SAT, c);
			if (i < 3)
				check(32'(image_cfg.black), (i == 0) ? 32'd0 : (i == 1) ? 32'd1 : 32'd50);
			check({20'h0, image_cfg.hue_rot}, {20'h0, 12'((c - 128) * 15)});
			check(32'(image_cfg.sat_scale), 32'(c));
		end
		for (int i = 0; i < 4; i++)
		begin
			wr(`OFF_CTRL, 32'(i) << 5);
			check(32'(image_cfg.gamma), (i == 3) ? 32'h0 : 32'(i));
		end
		wr(`OFF_CTRL, 32'h1 << 9);
		gains(`WB_3200_R, `WB_3200_B);
		wr(`OFF_CTRL, 32'h2 << 9);
		gains(`WB_5600_R, `WB_5600_B);
		wr(`OFF_WB, 32'h8080);
		wr(`OFF_CTRL, 32'h2 << 7);
		u_far.send_meas(8'h80, 8'h05, 8'hfd);
		gains(8'h7f, 8'h81);
		wr(`OFF_CTRL, 32'h0);
		u_far.send_meas(8'h80, 8'h05, 8'hfd);
		gains(8'h7f, 8'h81);
		wr(`OFF_CTRL, 32'h1 << 7);
		u_far.send_meas(8'h80, 8'h05, 8'hfd);
		gains(8'h7f, 8'h81);
		wr(`OFF_CMD, 32'h2);
		repeat (2) u_far.send_meas(8'h80, 8'h05, 8'hfd);
		gains(8'h7e, 8'h82);
		wr(`OFF_CTRL, 32'h4);
		wr(`OFF_GAIN, 32'd10);
		u_far.send_meas(8'h80, 8'h00, 8'h00);
		check(32'(image_cfg.gain_db), 32'd10);
		wr(`OFF_AE, 32'h0);
		u_far.send_meas(8'h80, 8'h00, 8'h00);
		check(32'(image_cfg.gain_db), 32'd9);
		repeat (12) u_far.send_meas(8'h00, 8'h00, 8'h00);
		check(32'(image_cfg.gain_db), 32'd18);
		wr(`OFF_CTRL, 32'h0);
		wr(`OFF_GAIN, 32'd5);
		u_far.send_meas(8'h00, 8'h00, 8'h00);
		check(32'(image_cfg.gain_db), 32'd5);
		wr(`OFF_AE, 32'h80);
		wr(`OFF_IRIS, 32'h20);
		wr(`OFF_CTRL, 32'h10);
		u_far.send_meas(8'h00, 8'h00, 8'h00);
		check(32'(image_cfg.iris), 32'h1f);
		wr(`OFF_SHUTTER, 32'd10);
		wr(`OFF_CTRL, 32'h8);
		repeat (3) u_far.send_meas(8'hff, 8'h00, 8'h00);
		check(32'(image_cfg.expo_tick >= 50 && image_cfg.expo_tick <= 3333), 32'h1);
		wr(`OFF_CTRL, 32'h1);
		check({30'h0, stream_on, lamp.orange}, 32'h3);
		wr(`OFF_CMD, 32'h1);
		apb(1'b0, `OFF_STATUS, 32'h0);
		check(32'(rd[2:0]), 32'h0);
		wr(`OFF_SHUTTER, 32'd1);
		wr(`OFF_CTRL, 32'h3);
		check(32'(stream_on), 32'h0);
		n = fs_count;
		k = exp_rises;
		u_far.pull_trigger(TRIG_MIN - 8);
		repeat (250) @(posedge pclk);
		check(32'(fs_count == n && exp_rises == k), 32'h1);
		u_far.pull_trigger(TRIG_MIN + 10);
		wait_change(exp_rises, k, 50);
		check(32'(rise_cyc - fall_cyc >= TRIG_MIN && rise_cyc - fall_cyc <= TRIG_MIN + 6), 32'h1);
		wait_change(fs_count, n, 1000);
		@(posedge pclk);
		check(32'(fs_cyc - rise_cyc >= 400 && fs_cyc - rise_cyc <= 505), 32'h1);
		wr(`OFF_CTRL, 32'h0);
		repeat (100) @(posedge pclk);
		check(32'(fs_count), 32'(n + 1));
		n = fs_count;
		k = exp_rises;
		v = cycles;
		wr(`OFF_CMD, 32'h1);
		wait_change(exp_rises, k, SHOT_MAX + 10);
		check(32'(rise_cyc - v <= SHOT_MAX + 8), 32'h1);
		wait_change(fs_count, n, 1000);
		repeat (2) @(posedge pclk);
		check(32'(lamp.orange), 32'h1);
		wr(`OFF_CMD, 32'h1);
		repeat (700) @(posedge pclk);
		check(32'(fs_count), 32'(n + 1));
		apb(1'b0, `OFF_STATUS, 32'h0);
		check(32'(rd[2:0]), 32'h0);
		final_report();
	end
endmodule
